// ===== lcbr_pkg.sv
// constants shared by the light regulation bus-return block
package lcbr_pkg;
	// register offsets (byte addresses)
	localparam logic [7:0] LCBR_CTRL_OFS = 8'h00;
	localparam logic [7:0] LCBR_CMD_OFS = 8'h04;
	localparam logic [7:0] LCBR_STATUS_OFS = 8'h08;
	localparam logic [7:0] LCBR_LEVEL_OFS = 8'h0c;
	// control field positions
	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_WITH_FMB_BIT = 1;
	localparam int CTRL_FB_ACTIVE_BIT = 2;
	localparam int CTRL_RET_LO = 3;
	// command field positions (write-only, self-clearing)
	localparam int CMD_DIS_SET_BIT = 0;
	localparam int CMD_DIS_CLR_BIT = 1;
	localparam int CMD_READ_BIT = 2;
	// status field positions
	localparam int ST_DISABLED_BIT = 0;
	localparam int ST_LEVEL_VALID_BIT = 1;
	localparam int ST_ACTIVE_BIT = 2;
	localparam int ST_WAIT_BIT = 3;
	localparam int ST_BUS_OK_BIT = 4;
	localparam int ST_RETAINED_BIT = 5;
	// reset value of control: disabled, active feedback, no reaction
	localparam logic [4:0] CTRL_RESET = 5'h04;
	// bus-return options
	typedef enum logic [1:0] {
		RET_NONE = 2'h0,
		RET_FORCE = 2'h1,
		RET_RESTORE = 2'h2
	} lcbr_ret_t;
	// reply timeout for a passive read request
	localparam int CLK_MHZ = 100;
	localparam int REPLY_TIMEOUT_US = 1000;
	localparam int REPLY_TIMEOUT_CYC = REPLY_TIMEOUT_US * CLK_MHZ;
endpackage : lcbr_pkg

// ===== lcbr_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module lcbr_sync (
	// clock and reset
	input wire logic sys_clk_in,
	input wire logic srst_in,
	// pin and filtered level
	input wire logic pin_in,
	output logic level_out
);
	logic s1_reg, s2_reg, s3_reg, lvl_reg;
	logic lvl_next;

	// change accepted only once stages two and three agree
	always_comb begin
		lvl_next = (s2_reg == s3_reg) ? s3_reg : lvl_reg;
	end

	always_ff @(posedge sys_clk_in) begin
		if (srst_in) begin
			s1_reg <= 1'b0;
			s2_reg <= 1'b0;
			s3_reg <= 1'b0;
			lvl_reg <= 1'b0;
		end else begin
			s1_reg <= pin_in;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			lvl_reg <= lvl_next;
		end
	end

	assign level_out = lvl_reg;
endmodule : lcbr_sync

// ===== lcbr_timer.sv
// one-shot timeout counter, restartable
`timescale 1ns/1ps
module lcbr_timer #(
	parameter int CYCLES = 100000
) (
	// clock and reset
	input wire logic sys_clk_in,
	input wire logic srst_in,
	// control
	input wire logic start_in,
	input wire logic stop_in,
	// one-cycle pulse when the time has run out
	output logic expire_out
);
	localparam int CW = $clog2(CYCLES + 1);
	logic [CW-1:0] cnt_reg, cnt_next;
	logic run_reg, run_next, exp_reg, exp_next;

	// start wins over stop so a restart is never lost
	always_comb begin
		cnt_next = cnt_reg;
		run_next = run_reg;
		exp_next = 1'b0;
		if (start_in) begin
			cnt_next = CW'(CYCLES - 1);
			run_next = 1'b1;
		end else if (stop_in) begin
			run_next = 1'b0;
		end else if (run_reg) begin
			if (cnt_reg == '0) begin
				run_next = 1'b0;
				exp_next = 1'b1;
			end else begin
				cnt_next = cnt_reg - CW'(1);
			end
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (srst_in) begin
			cnt_reg <= '0;
			run_reg <= 1'b0;
			exp_reg <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			run_reg <= run_next;
			exp_reg <= exp_next;
		end
	end

	assign expire_out = exp_reg;
endmodule : lcbr_timer

// ===== lcbr_top.sv
// light regulation: brightness feedback path and bus-return disable handling
//
// The register addresses and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
module lcbr_top
	import lcbr_pkg::*;
#(
	parameter int LEVEL_W = 8,
	parameter int REPLY_CYC = lcbr_pkg::REPLY_TIMEOUT_CYC
) (
	// clock and reset
	input wire logic sys_clk_in,
	input wire logic srst_in,
	// register port
	input wire logic [7:0] reg_addr_in,
	input wire logic [31:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [31:0] reg_rdata_out,
	// bus voltage pin
	input wire logic bus_ok_in,
	// actuator brightness feedback, same clock
	input wire logic fb_valid_in,
	input wire logic [LEVEL_W-1:0] fb_level_in,
	// towards the bus and the regulation loop
	output logic fb_read_req_out,
	output logic disable_start_out,
	output logic regulation_active_out,
	output logic disabled_out,
	output logic [LEVEL_W-1:0] level_out
);
	import lcbr_pkg::*;

	typedef enum logic [3:0] {
		S_DOWN = 4'h1,
		S_RETURN = 4'h2,
		S_WAIT = 4'h4,
		S_RUN = 4'h8
	} lcbr_state_t;

	// register decode, used by both the write and the read path
	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		hit = (a == ofs);
	endfunction : hit

	logic bus_ok;
	logic timeout;
	logic timer_start;
	logic timer_stop;

	lcbr_state_t state_reg, state_next;
	logic [4:0] ctrl_reg, ctrl_next;
	logic dis_reg, dis_next;
	logic keep_reg, keep_next;
	logic valid_reg, valid_next;
	logic [LEVEL_W-1:0] level_reg, level_next;
	logic req_reg, req_next;
	logic dstart_reg, dstart_next;
	logic bus_prev_reg, bus_prev_next;
	logic [31:0] rdata_reg, rdata_next;

	logic en_eff;
	logic passive;
	lcbr_ret_t ret_opt;
	logic wr_ctrl, wr_cmd;
	logic sw_dis_set, sw_dis_clr, sw_read;
	logic sw_ok;
	logic [31:0] status_word;

	// bus voltage comes from a pin, so it is filtered before use
	lcbr_sync u_bus_sync (
		.sys_clk_in(sys_clk_in),
		.srst_in(srst_in),
		.pin_in(bus_ok_in),
		.level_out(bus_ok)
	);

	// a passive actuator may miss a request; the timer re-arms it
	lcbr_timer #(
		.CYCLES(REPLY_CYC)
	) u_reply_timer (
		.sys_clk_in(sys_clk_in),
		.srst_in(srst_in),
		.start_in(timer_start),
		.stop_in(timer_stop),
		.expire_out(timeout)
	);

	// configuration views
	assign en_eff = ctrl_reg[CTRL_EN_BIT] | ctrl_reg[CTRL_WITH_FMB_BIT];
	assign passive = ~ctrl_reg[CTRL_FB_ACTIVE_BIT];
	assign ret_opt = lcbr_ret_t'(ctrl_reg[CTRL_RET_LO +: 2]);

	// register write strobes
	assign wr_ctrl = reg_wr_in & hit(reg_addr_in, LCBR_CTRL_OFS);
	assign wr_cmd = reg_wr_in & hit(reg_addr_in, LCBR_CMD_OFS);
	assign sw_dis_set = wr_cmd & reg_wdata_in[CMD_DIS_SET_BIT];
	assign sw_dis_clr = wr_cmd & reg_wdata_in[CMD_DIS_CLR_BIT];
	assign sw_read = wr_cmd & reg_wdata_in[CMD_READ_BIT];

	// software disable commands are refused while the bus is down or the return option is applied
	assign sw_ok = bus_ok & (state_reg != S_DOWN) & (state_reg != S_RETURN);

	// sequencing of bus failure, bus return and feedback acquisition
	// down: the level is stale, nothing is requested and the disable state is frozen
	// return: lasts one cycle and applies the configured bus-return option
	// wait: passive mode only; the level is not trusted until the actuator answers
	// run: normal work; in passive mode software may ask for a fresh level
	// a bus drop in any state leads straight back to down, so a short dip
	// still replays the whole return sequence once the bus is back
	always_comb begin
		state_next = state_reg;
		ctrl_next = ctrl_reg;
		dis_next = dis_reg;
		keep_next = keep_reg;
		valid_next = valid_reg;
		level_next = level_reg;
		req_next = 1'b0;
		dstart_next = 1'b0;
		bus_prev_next = bus_ok;
		timer_start = 1'b0;
		timer_stop = 1'b0;
		if (wr_ctrl) begin
			ctrl_next = reg_wdata_in[4:0];
		end
		// any report while the bus is up is taken as the level; in active mode it is unsolicited
		if (fb_valid_in && bus_ok) begin
			level_next = fb_level_in;
			valid_next = 1'b1;
		end

		// main sequence; what a state decides shows one cycle later on the registers
		case (state_reg)
			S_DOWN: begin
				// level is stale while the bus is down; disable state is kept
				valid_next = 1'b0;
				if (bus_ok && !bus_prev_reg) begin
					state_next = S_RETURN;
				end
			end

			// one cycle only: apply the configured bus-return option
			S_RETURN: begin
				case (ret_opt)
					RET_FORCE: begin
						dis_next = 1'b1;
						dstart_next = 1'b1;
					end
					RET_RESTORE: begin
						dis_next = keep_reg;
						dstart_next = keep_reg;
					end
					RET_NONE: begin
						dis_next = 1'b0;
					end
					// the unused fourth code is treated as no reaction
					default: begin
						dis_next = 1'b0;
					end
				endcase
				if (passive) begin
					req_next = 1'b1;
					timer_start = 1'b1;
					valid_next = 1'b0;
					state_next = S_WAIT;
				end else begin
					state_next = S_RUN;
				end
			end

			S_WAIT: begin
				// regulation waits for the first answer before using the level
				if (fb_valid_in) begin
					timer_stop = 1'b1;
					state_next = S_RUN;
				end else if (timeout) begin
					req_next = 1'b1;
					timer_start = 1'b1;
				end
			end

			// software may ask for a fresh level, in passive mode only
			S_RUN: begin
				if (sw_read && passive) begin
					req_next = 1'b1;
					timer_start = 1'b1;
					state_next = S_WAIT;
				end
			end

			// an illegal code falls back to the safe down state
			default: begin
				state_next = S_DOWN;
			end
		endcase

		// software disable; a fresh disable runs the start actions once, set beats clear
		if (sw_ok) begin
			if (sw_dis_set) begin
				dstart_next = ~dis_reg;
				dis_next = 1'b1;
			end else if (sw_dis_clr) begin
				dis_next = 1'b0;
			end
		end

		// the held copy follows the live state only while software disable commands are accepted (bus up, not in down or return)
		if (sw_ok) begin
			keep_next = dis_next;
		end

		// bus failure overrides everything but a control write and a timer start, even a return option applied in the same cycle
		if (!bus_ok) begin
			state_next = S_DOWN;
			dis_next = dis_reg; // disable state is frozen, so no rise without its start pulse
			valid_next = 1'b0;
			req_next = 1'b0;
			dstart_next = 1'b0;
			timer_stop = 1'b1;
		end
	end

	// sequence registers; reset leaves the bus considered down
	always_ff @(posedge sys_clk_in) begin
		if (srst_in) begin
			state_reg <= S_DOWN;
			ctrl_reg <= CTRL_RESET;
			dis_reg <= 1'b0;
			keep_reg <= 1'b0;
			valid_reg <= 1'b0;
			level_reg <= '0;
			req_reg <= 1'b0;
			dstart_reg <= 1'b0;
			bus_prev_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			ctrl_reg <= ctrl_next;
			dis_reg <= dis_next;
			keep_reg <= keep_next;
			valid_reg <= valid_next;
			level_reg <= level_next;
			req_reg <= req_next;
			dstart_reg <= dstart_next;
			bus_prev_reg <= bus_prev_next;
		end
	end

	// status word, gathered in one place so the read path stays a plain mux
	always_comb begin
		status_word = 32'h0;
		status_word[ST_DISABLED_BIT] = dis_reg;
		status_word[ST_LEVEL_VALID_BIT] = valid_reg;
		status_word[ST_ACTIVE_BIT] = regulation_active_out;
		status_word[ST_WAIT_BIT] = (state_reg == S_WAIT);
		status_word[ST_BUS_OK_BIT] = bus_ok;
		status_word[ST_RETAINED_BIT] = keep_reg;
	end

	// read data: registered, valid only in the cycle after the strobe
	always_comb begin
		// the command register is write-only and reads back as zero
		rdata_next = 32'h0;
		if (reg_rd_in) begin
			if (hit(reg_addr_in, LCBR_CTRL_OFS)) begin
				rdata_next[4:0] = ctrl_reg;
			end else if (hit(reg_addr_in, LCBR_STATUS_OFS)) begin
				rdata_next = status_word;
			end else if (hit(reg_addr_in, LCBR_LEVEL_OFS)) begin
				rdata_next[LEVEL_W-1:0] = level_reg;
			end
		end
	end

	// read data register; zero outside the answer cycle
	always_ff @(posedge sys_clk_in) begin
		if (srst_in) begin
			rdata_reg <= 32'h0;
		end else begin
			rdata_reg <= rdata_next;
		end
	end

	// outputs
	assign reg_rdata_out = rdata_reg;
	assign fb_read_req_out = req_reg;
	assign disable_start_out = dstart_reg;
	assign disabled_out = dis_reg;
	assign level_out = level_reg;
	// regulation needs a known level, which the feedback wiring provides
	assign regulation_active_out = en_eff & ~dis_reg & valid_reg & (state_reg == S_RUN);
endmodule : lcbr_top

// ===== lcbr_props.sv
// assertions on the light regulation bus-return ports
`timescale 1ns/1ps
module lcbr_props
	import lcbr_pkg::*;
#(
	parameter int LEVEL_W = 8,
	parameter int REPLY_CYC = REPLY_TIMEOUT_CYC
) (
	// clock and reset
	input wire logic sys_clk_in,
	input wire logic srst_in,
	// register port
	input wire logic [7:0] reg_addr_in,
	input wire logic [31:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [31:0] reg_rdata_out,
	// bus pin and actuator feedback
	input wire logic bus_ok_in,
	input wire logic fb_valid_in,
	input wire logic [LEVEL_W-1:0] fb_level_in,
	// block outputs
	input wire logic fb_read_req_out,
	input wire logic disable_start_out,
	input wire logic regulation_active_out,
	input wire logic disabled_out,
	input wire logic [LEVEL_W-1:0] level_out
);
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (srst_in);
	// read data stand only in the answer cycle
	a_rdata_idle: assert property (
		!$past(reg_rd_in) |-> reg_rdata_out == 32'h0)
		else $error("read data outside answer cycle");
	// start-of-disable is a single pulse
	a_start_pulse: assert property (
		disable_start_out |=> !disable_start_out)
		else $error("start pulse too long");
	a_start_dis: assert property (
		disable_start_out |-> disabled_out)
		else $error("start pulse without disable");
	// every entry into disable runs the start actions
	a_rise_start: assert property (
		$rose(disabled_out) |-> disable_start_out)
		else $error("disable without start pulse");
	// requests are single pulses, never straight repeated
	a_req_gap: assert property (
		fb_read_req_out |=> (!fb_read_req_out) [*2])
		else $error("read request repeated");
	// level only moves on an actuator report
	a_level_src: assert property (
		level_out != $past(level_out) |-> $past(fb_valid_in) && level_out == $past(fb_level_in))
		else $error("level changed without report");
	a_act_enabled: assert property (
		regulation_active_out |-> !disabled_out)
		else $error("regulation active while disabled");
	// after a bus loss the level is stale, so no regulation
	a_down_inactive: assert property (
		$fell(bus_ok_in) ##1 (!bus_ok_in) [*6] |-> !regulation_active_out)
		else $error("regulation active with bus down");
endmodule : lcbr_props
bind lcbr_top lcbr_props #(.LEVEL_W(LEVEL_W), .REPLY_CYC(REPLY_CYC)) props_u (.sys_clk_in, .srst_in,
	.reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .bus_ok_in, .fb_valid_in,
	.fb_level_in, .fb_read_req_out, .disable_start_out, .regulation_active_out, .disabled_out, .level_out);

// ===== lcbr_act_model.sv
// dimming actuator on output channel 1: reports and read replies
`timescale 1ns/1ps
module lcbr_act_model (
	// clock
	input wire logic sys_clk_in,
	// bench control: report now, level, reply delay
	input wire logic push_in,
	input wire logic [7:0] lvl_in,
	input wire logic [7:0] dly_in,
	// request from the regulation
	input wire logic req_in,
	// report towards the regulation
	output logic valid_out,
	output logic [7:0] level_out
);
	logic [8:0] cnt_reg = 9'h0;
	logic [7:0] last_reg = 8'h0;
	// data lines hold the inverse of the last report between reports so stale values never match
	always_ff @(posedge sys_clk_in) begin
		valid_out <= 1'b0;
		level_out <= ~last_reg;
		if (req_in) begin
			cnt_reg <= {1'b0, dly_in} + 9'h1;
		end else if (cnt_reg != 9'h0) begin
			cnt_reg <= cnt_reg - 9'h1;
		end
		if (push_in || cnt_reg == 9'h1) begin
			valid_out <= 1'b1;
			level_out <= lvl_in;
			last_reg <= lvl_in;
		end
	end
endmodule : lcbr_act_model

// ===== lcbr_tb.sv
// self-checking bench for the light regulation bus-return block
`timescale 1ns/1ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin miscompares++; $display("Error %s exp %0h got %0h", n, e, g); end end
module testbench;
	import lcbr_pkg::*;
	logic sys_clk_in = 1'b0;
	logic srst_in = 1'b1;
	logic [7:0] reg_addr_in = 8'h0;
	logic [31:0] reg_wdata_in = 32'h0;
	logic reg_wr_in = 1'b0;
	logic reg_rd_in = 1'b0;
	logic bus_ok_in = 1'b0;
	logic push = 1'b0;
	logic [7:0] lvl = 8'h0;
	logic [7:0] dly = 8'h02;
	logic [31:0] reg_rdata_out;
	logic fb_valid_in, fb_read_req_out, disable_start_out, regulation_active_out, disabled_out;
	logic [7:0] fb_level_in, level_out;
	int miscompares = 0;
	int compares = 0;
	int cyc = 0;
	int starts = 0;
	int reqs = 0;
	int s0, r0;
	always #5 sys_clk_in = ~sys_clk_in;
	lcbr_top #(.LEVEL_W(8), .REPLY_CYC(20)) dut_u (.sys_clk_in, .srst_in, .reg_addr_in, .reg_wdata_in,
		.reg_wr_in, .reg_rd_in, .reg_rdata_out, .bus_ok_in, .fb_valid_in, .fb_level_in, .fb_read_req_out,
		.disable_start_out, .regulation_active_out, .disabled_out, .level_out);
	lcbr_act_model act_u (.sys_clk_in, .push_in(push), .lvl_in(lvl), .dly_in(dly), .req_in(fb_read_req_out),
		.valid_out(fb_valid_in), .level_out(fb_level_in));
	// pulse counters and hang guard
	always @(posedge sys_clk_in) begin
		cyc++;
		starts += disable_start_out;
		reqs += fb_read_req_out;
		if (cyc == 4000) begin
			miscompares++;
			finish_test();
		end
	end
	task automatic finish_test();
		if (miscompares == 0 && compares > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : finish_test
	task automatic settle(input int n);
		repeat (n) @(posedge sys_clk_in);
		#1;
	endtask : settle
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk_in);
		reg_addr_in <= a;
		reg_wdata_in <= d;
		reg_wr_in <= 1'b1;
		@(posedge sys_clk_in);
		reg_wr_in <= 1'b0;
		settle(1);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
		@(posedge sys_clk_in);
		reg_addr_in <= a;
		reg_rd_in <= 1'b1;
		@(posedge sys_clk_in);
		reg_rd_in <= 1'b0;
		#1;
		`CHK(n, e, reg_rdata_out)
	endtask : rd
	// synchroniser plus reply delay fit well inside the wait
	task automatic bus(input logic v);
		// baselines are taken before the change so the return pulses are counted
		s0 = starts;
		r0 = reqs;
		@(posedge sys_clk_in);
		bus_ok_in <= v;
		settle(16);
	endtask : bus
	task automatic report(input logic [7:0] v);
		@(posedge sys_clk_in);
		lvl <= v;
		push <= 1'b1;
		@(posedge sys_clk_in);
		push <= 1'b0;
		settle(3);
	endtask : report
	initial begin
		repeat (20) @(posedge sys_clk_in);
		srst_in <= 1'b0;
		rd(LCBR_CTRL_OFS, {27'h0, CTRL_RESET}, "ctrl reset");
		rd(8'h10, 32'h0, "unmapped");
		rd(LCBR_CMD_OFS, 32'h0, "cmd read");
		// own enable off but tied to the first motion block, active feedback
		wr(LCBR_CTRL_OFS, 32'h06);
		bus(1'b1);
		`CHK("dis none", 1'b0, disabled_out)
		report(8'h5a);
		`CHK("level act", 8'h5a, level_out)
		`CHK("reg act", 1'b1, regulation_active_out)
		rd(LCBR_LEVEL_OFS, 32'h5a, "level reg");
		// enabled, passive, forced disable on return
		bus(1'b0);
		`CHK("down act", 1'b0, regulation_active_out)
		wr(LCBR_CTRL_OFS, 32'h09);
		lvl <= 8'h33;
		bus(1'b1);
		`CHK("dis force", 1'b1, disabled_out)
		`CHK("start force", 1, starts - s0)
		`CHK("req ret", 1, reqs - r0)
		`CHK("level pas", 8'h33, level_out)
		`CHK("act dis", 1'b0, regulation_active_out)
		rd(LCBR_STATUS_OFS, 32'h33, "status force");
		// software clear, set, set again: only a fresh disable pulses
		wr(LCBR_CMD_OFS, 32'h2);
		`CHK("act clr", 1'b1, regulation_active_out)
		rd(LCBR_STATUS_OFS, 32'h16, "status run");
		s0 = starts;
		wr(LCBR_CMD_OFS, 32'h1);
		wr(LCBR_CMD_OFS, 32'h1);
		`CHK("sw start", 1, starts - s0)
		// restore: disabled comes back with its start actions
		wr(LCBR_CTRL_OFS, 32'h11);
		bus(1'b0);
		bus(1'b1);
		`CHK("dis rest", 1'b1, disabled_out)
		`CHK("start rest", 1, starts - s0)
		wr(LCBR_CMD_OFS, 32'h2);
		bus(1'b0);
		bus(1'b1);
		`CHK("en rest", 1'b0, disabled_out)
		`CHK("no start", 0, starts - s0)
		// software read request in passive run
		lvl <= 8'h77;
		wr(LCBR_CMD_OFS, 32'h4);
		settle(6);
		`CHK("sw read", 8'h77, level_out)
		// silent actuator: the request is repeated after the reply timeout
		dly <= 8'hff;
		bus(1'b0);
		bus(1'b1);
		settle(40);
		`CHK("timeout req", 1'b1, (reqs - r0) >= 2)
		rd(LCBR_STATUS_OFS, 32'h18, "status wait");
		finish_test();
	end
endmodule : testbench
